// ===== cvr_pkg.sv
// Package with offsets, fields, reset values and carrier types of the converter config bank
`default_nettype none
package cvr_pkg;
  localparam logic [7:0] OFS_PORT_SETUP = 8'h00;
  localparam logic [7:0] OFS_ADC_SELECT = 8'h05;
  localparam logic [7:0] OFS_CM_BUF = 8'h0F;
  localparam logic [7:0] OFS_ADC_OFFSET = 8'h10;
  localparam logic [7:0] OFS_FILTER = 8'h30;
  localparam logic [7:0] OFS_CLK_DIV_N = 8'h71;
  localparam logic [7:0] OFS_LOOP_DIV_M = 8'h72;
  localparam logic [7:0] OFS_LOOP_RESET = 8'h75;
  localparam logic [7:0] OFS_AUX_CHAN = 8'h77;
  localparam logic [7:0] OFS_AUX_HIGH = 8'h78;
  localparam logic [7:0] OFS_AUX_LOW = 8'h79;
  localparam logic [7:0] OFS_AUX_EN = 8'h7A;
  localparam logic [7:0] OFS_TEMP_REF = 8'h7B;
  localparam logic [7:0] OFS_RX_FSADJ = 8'h7D;
  localparam logic [7:0] OFS_RX_TRIM = 8'h7E;
  localparam logic [7:0] OFS_I_TRIM_HI = 8'h7F;
  localparam logic [7:0] OFS_I_TRIM_LO = 8'h80;
  localparam logic [7:0] OFS_Q_TRIM_HI = 8'h81;
  localparam logic [7:0] OFS_Q_TRIM_LO = 8'h82;
  localparam logic [7:0] OFS_TRANSFER = 8'hFF;
  // Field positions; the port_setup fields are mirrored (upper, lower)
  localparam int POS_DIR_HI = 7;
  localparam int POS_DIR_LO = 0;
  localparam int POS_ORDER_HI = 6;
  localparam int POS_ORDER_LO = 1;
  localparam int POS_SRST_HI = 5;
  localparam int POS_SRST_LO = 2;
  localparam int POS_INPHASE_SEL = 0;
  localparam int POS_QUAD_SEL = 1;
  localparam int POS_CM_EN = 1;
  localparam int POS_DECIM_BYPASS = 5;
  localparam int POS_SECOND_INTERP = 4;
  localparam int POS_FIRST_INTERP = 3;
  localparam int POS_UPDATE = 0;
  localparam int POS_LOCKED = 7;
  localparam logic [7:0] RST_PORT_SETUP = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LOOP_DIV_M = 8'h01;
  localparam logic [7:0] MASK_LOOP_DIV_M = 8'h7F;
  localparam logic [7:0] MASK_ADC_SELECT = 8'h03;
  localparam logic [7:0] MASK_CM_BUF = 8'h02;
  localparam logic [7:0] MASK_ADC_OFFSET = 8'h3F;
  localparam logic [7:0] MASK_FILTER = 8'h3F;
  localparam int GEN_COUNT = 13;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cvr_req_s;

  typedef struct packed {
    logic cm_en;
    logic [5:0] offset;
  } cvr_adc_cfg_s;

  typedef struct packed {
    logic [11:0] result;
    logic done;
    logic [2:0] chan;
  } cvr_aux_s;
endpackage
`default_nettype wire

// ===== cvr_config_regs.sv
// Configuration register bank behind the serial configuration port
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Pin-direction bit 0 gives a two-way data pin, 1 gives input only; mirrored.
// - Bit-order bit 0 sends MSB first, 1 sends LSB first; mirrored at 6 and 1.
// - A 0-to-1 soft-reset bit resets every register except the port setup register.
// - Select field picks none, in-phase, quadrature or both converters for specific writes.
// - Buffer enable bit drives the common-mode output; zero leaves it high impedance.
// - Six-bit two's-complement offset from +31 to -32 LSB per addressed converter.
// - Filter bit 5 bypasses the receive factor-of-two decimator.
// - Filter bit 4 bypasses second interpolator, bit 3 bypasses first interpolator.
module cvr_config_regs (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire cvr_pkg::cvr_req_s req,
  input wire logic dll_locked,
  input wire cvr_pkg::cvr_aux_s aux_status,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic sdio_input_only,
  output logic lsb_first,
  output cvr_pkg::cvr_adc_cfg_s adc_i_cfg,
  output cvr_pkg::cvr_adc_cfg_s adc_q_cfg,
  output logic rx_common_mode_buffer_en,
  output logic decimator_bypass,
  output logic second_interp_bypass,
  output logic first_interp_bypass
);
  // Storage index of plain read/write registers; bit 4 flags a hit
  function automatic logic [4:0] gen_index(input logic [7:0] addr);
    unique case (addr)
      cvr_pkg::OFS_FILTER: gen_index = 5'h10;
      cvr_pkg::OFS_CLK_DIV_N: gen_index = 5'h11;
      cvr_pkg::OFS_LOOP_DIV_M: gen_index = 5'h12;
      cvr_pkg::OFS_LOOP_RESET: gen_index = 5'h13;
      cvr_pkg::OFS_AUX_CHAN: gen_index = 5'h14;
      cvr_pkg::OFS_AUX_EN: gen_index = 5'h15;
      cvr_pkg::OFS_TEMP_REF: gen_index = 5'h16;
      cvr_pkg::OFS_RX_FSADJ: gen_index = 5'h17;
      cvr_pkg::OFS_RX_TRIM: gen_index = 5'h18;
      cvr_pkg::OFS_I_TRIM_HI: gen_index = 5'h19;
      cvr_pkg::OFS_I_TRIM_LO: gen_index = 5'h1A;
      cvr_pkg::OFS_Q_TRIM_HI: gen_index = 5'h1B;
      cvr_pkg::OFS_Q_TRIM_LO: gen_index = 5'h1C;
      default: gen_index = 5'h00;
    endcase
  endfunction

  function automatic logic [7:0] gen_reset(input int idx);
    gen_reset = (idx == 2) ? cvr_pkg::RST_LOOP_DIV_M : cvr_pkg::RST_ZERO;
  endfunction

  // A mirrored bit is set by either copy of the field
  function automatic logic mirror(input logic [7:0] v, input int hi, input int lo);
    mirror = v[hi] | v[lo];
  endfunction

  logic [7:0] port_setup;
  logic [1:0] adc_select;
  logic [7:0] shadow_cm;
  logic [7:0] shadow_offset;
  logic transfer_bit;
  logic [7:0] gen_reg [cvr_pkg::GEN_COUNT];
  logic wr_hit;
  logic soft_rst;
  logic update_rise;
  logic [4:0] gen_sel;
  logic [7:0] next_rd_data;

  assign wr_hit = clk_en & req.wr;
  assign gen_sel = gen_index(req.addr);

  // Soft reset fires on the write that raises the reset field
  assign soft_rst = wr_hit && req.addr == cvr_pkg::OFS_PORT_SETUP
    && mirror(req.wdata, cvr_pkg::POS_SRST_HI, cvr_pkg::POS_SRST_LO)
    && !mirror(port_setup, cvr_pkg::POS_SRST_HI, cvr_pkg::POS_SRST_LO);

  assign update_rise = wr_hit && req.addr == cvr_pkg::OFS_TRANSFER
    && req.wdata[cvr_pkg::POS_UPDATE] && !transfer_bit;

  // Port setup survives the soft reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port_setup <= cvr_pkg::RST_PORT_SETUP;
    end else if (wr_hit && req.addr == cvr_pkg::OFS_PORT_SETUP) begin
      port_setup <= req.wdata;
    end
  end

  assign sdio_input_only = mirror(port_setup, cvr_pkg::POS_DIR_HI, cvr_pkg::POS_DIR_LO);
  assign lsb_first = mirror(port_setup, cvr_pkg::POS_ORDER_HI, cvr_pkg::POS_ORDER_LO);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      adc_select <= 2'h0;
    end else if (soft_rst) begin
      adc_select <= 2'h0;
    end else if (wr_hit && req.addr == cvr_pkg::OFS_ADC_SELECT) begin
      adc_select <= req.wdata[1:0];
    end
  end

  // Converter-specific writes land in shadow storage only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      shadow_cm <= cvr_pkg::RST_ZERO;
      shadow_offset <= cvr_pkg::RST_ZERO;
    end else if (soft_rst) begin
      shadow_cm <= cvr_pkg::RST_ZERO;
      shadow_offset <= cvr_pkg::RST_ZERO;
    end else if (wr_hit && req.addr == cvr_pkg::OFS_CM_BUF) begin
      shadow_cm <= req.wdata & cvr_pkg::MASK_CM_BUF;
    end else if (wr_hit && req.addr == cvr_pkg::OFS_ADC_OFFSET) begin
      shadow_offset <= req.wdata & cvr_pkg::MASK_ADC_OFFSET;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      transfer_bit <= 1'b0;
    end else if (soft_rst) begin
      transfer_bit <= 1'b0;
    end else if (wr_hit && req.addr == cvr_pkg::OFS_TRANSFER) begin
      transfer_bit <= req.wdata[cvr_pkg::POS_UPDATE];
    end
  end

  // Update edge copies the shadows into each selected converter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      adc_i_cfg <= '0;
      adc_q_cfg <= '0;
    end else if (soft_rst) begin
      adc_i_cfg <= '0;
      adc_q_cfg <= '0;
    end else if (update_rise) begin
      if (adc_select[cvr_pkg::POS_INPHASE_SEL]) begin
        adc_i_cfg <= {shadow_cm[cvr_pkg::POS_CM_EN], shadow_offset[5:0]};
      end
      if (adc_select[cvr_pkg::POS_QUAD_SEL]) begin
        adc_q_cfg <= {shadow_cm[cvr_pkg::POS_CM_EN], shadow_offset[5:0]};
      end
    end
  end

  // Buffer is driven while either converter has it enabled
  assign rx_common_mode_buffer_en = adc_i_cfg.cm_en | adc_q_cfg.cm_en;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < cvr_pkg::GEN_COUNT; i++) begin
        gen_reg[i] <= cvr_pkg::RST_ZERO;
      end
      gen_reg[2] <= cvr_pkg::RST_LOOP_DIV_M;
    end else if (soft_rst) begin
      for (int i = 0; i < cvr_pkg::GEN_COUNT; i++) begin
        gen_reg[i] <= gen_reset(i);
      end
    end else if (wr_hit && gen_sel[4]) begin
      if (req.addr == cvr_pkg::OFS_LOOP_DIV_M) begin
        gen_reg[gen_sel[3:0]] <= req.wdata & cvr_pkg::MASK_LOOP_DIV_M;
      end else if (req.addr == cvr_pkg::OFS_FILTER) begin
        gen_reg[gen_sel[3:0]] <= req.wdata & cvr_pkg::MASK_FILTER;
      end else begin
        gen_reg[gen_sel[3:0]] <= req.wdata;
      end
    end
  end

  assign decimator_bypass = gen_reg[0][cvr_pkg::POS_DECIM_BYPASS];
  assign second_interp_bypass = gen_reg[0][cvr_pkg::POS_SECOND_INTERP];
  assign first_interp_bypass = gen_reg[0][cvr_pkg::POS_FIRST_INTERP];

  // Readback; unmapped offsets read zero
  always_comb begin
    next_rd_data = 8'h00;
    if (gen_sel[4]) begin
      next_rd_data = gen_reg[gen_sel[3:0]];
    end
    unique case (req.addr)
      cvr_pkg::OFS_PORT_SETUP: next_rd_data = port_setup;
      cvr_pkg::OFS_ADC_SELECT: next_rd_data = {6'h00, adc_select};
      cvr_pkg::OFS_CM_BUF: next_rd_data = shadow_cm;
      cvr_pkg::OFS_ADC_OFFSET: next_rd_data = shadow_offset;
      cvr_pkg::OFS_LOOP_DIV_M: next_rd_data = {dll_locked, gen_reg[2][6:0]};
      cvr_pkg::OFS_AUX_HIGH: next_rd_data = aux_status.result[11:4];
      cvr_pkg::OFS_AUX_LOW: next_rd_data = {aux_status.result[3:0], aux_status.done,
        aux_status.chan};
      cvr_pkg::OFS_TRANSFER: next_rd_data = {7'h00, transfer_bit};
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= req.rd;
      if (req.rd) begin
        rd_data <= next_rd_data;
      end
    end
  end

  // Port setup: outputs follow the written byte and nothing else
  a_dir_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_hit && req.addr == cvr_pkg::OFS_PORT_SETUP |=> sdio_input_only
      == ($past(req.wdata[cvr_pkg::POS_DIR_HI]) | $past(req.wdata[cvr_pkg::POS_DIR_LO])))
    else $error("pin direction not taken from written setup");

  a_dir_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(wr_hit && req.addr == cvr_pkg::OFS_PORT_SETUP)
      |=> $stable(sdio_input_only) && $stable(lsb_first))
    else $error("port setup outputs moved without a setup write");

  a_order_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_hit && req.addr == cvr_pkg::OFS_PORT_SETUP |=> lsb_first
      == ($past(req.wdata[cvr_pkg::POS_ORDER_HI]) | $past(req.wdata[cvr_pkg::POS_ORDER_LO])))
    else $error("bit order not taken from written setup");

  a_soft_reset_clears: assert property (@(posedge clk_sys) disable iff (!rst_b)
    soft_rst |=> adc_select == 2'h0 && gen_reg[0] == cvr_pkg::RST_ZERO
      && gen_reg[2] == cvr_pkg::RST_LOOP_DIV_M && shadow_offset == cvr_pkg::RST_ZERO
      && port_setup == $past(req.wdata))
    else $error("soft reset left state or lost port setup");

  a_soft_reset_edge: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_hit && req.addr == cvr_pkg::OFS_PORT_SETUP
      && mirror(port_setup, cvr_pkg::POS_SRST_HI, cvr_pkg::POS_SRST_LO)
      |=> $stable(adc_select) && $stable(adc_i_cfg) && $stable(adc_q_cfg))
    else $error("soft reset fired without a rising reset bit");

  // Converter select and update edge
  a_select_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_hit && req.addr == cvr_pkg::OFS_ADC_SELECT |=> adc_select == $past(req.wdata[1:0]))
    else $error("converter select not taken from write");

  a_select_none: assert property (@(posedge clk_sys) disable iff (!rst_b)
    update_rise && adc_select == 2'h0 && !soft_rst
      |=> $stable(adc_i_cfg) && $stable(adc_q_cfg))
    else $error("update with no converter selected changed settings");

  a_select_inphase: assert property (@(posedge clk_sys) disable iff (!rst_b)
    update_rise && adc_select == 2'h1 |=> $stable(adc_q_cfg)
      && adc_i_cfg.offset == $past(shadow_offset[5:0]))
    else $error("in-phase update touched the wrong converter");

  a_select_quad: assert property (@(posedge clk_sys) disable iff (!rst_b)
    update_rise && adc_select == 2'h2 |=> $stable(adc_i_cfg)
      && adc_q_cfg.offset == $past(shadow_offset[5:0]))
    else $error("quadrature update touched the wrong converter");

  a_update_copy: assert property (@(posedge clk_sys) disable iff (!rst_b)
    update_rise && adc_select == 2'h3 |=> adc_q_cfg.offset == $past(shadow_offset[5:0])
      && adc_i_cfg == adc_q_cfg)
    else $error("update did not copy shadows to both converters");

  a_update_rearm: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_hit && req.addr == cvr_pkg::OFS_TRANSFER && transfer_bit
      |=> $stable(adc_i_cfg) && $stable(adc_q_cfg))
    else $error("update applied without a rising update bit");

  a_cm_buffer: assert property (@(posedge clk_sys) disable iff (!rst_b)
    update_rise && adc_select == 2'h3
      |=> rx_common_mode_buffer_en == $past(shadow_cm[cvr_pkg::POS_CM_EN]))
    else $error("buffer drive does not follow applied enable");

  a_offset_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_hit && req.addr == cvr_pkg::OFS_ADC_OFFSET && !soft_rst
      |=> shadow_offset == {2'b00, $past(req.wdata[5:0])})
    else $error("offset shadow does not hold six written bits");

  // Filter bypass bits
  a_filter_bypass: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_hit && req.addr == cvr_pkg::OFS_FILTER && !soft_rst
      |=> decimator_bypass == $past(req.wdata[cvr_pkg::POS_DECIM_BYPASS])
      && second_interp_bypass == $past(req.wdata[cvr_pkg::POS_SECOND_INTERP])
      && first_interp_bypass == $past(req.wdata[cvr_pkg::POS_FIRST_INTERP]))
    else $error("bypass bits do not follow filter register");

  a_bypass_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(wr_hit && req.addr == cvr_pkg::OFS_FILTER) && !soft_rst
      |=> $stable(decimator_bypass) && $stable(second_interp_bypass)
      && $stable(first_interp_bypass))
    else $error("bypass bits moved without a filter write");

  // Shadow storage reaches the converters only on the update edge
  a_shadow_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !update_rise && !soft_rst |=> $stable(adc_i_cfg) && $stable(adc_q_cfg))
    else $error("active settings changed without update edge");

  a_inphase_cm: assert property (@(posedge clk_sys) disable iff (!rst_b)
    update_rise && adc_select[cvr_pkg::POS_INPHASE_SEL]
      |=> adc_i_cfg.cm_en == $past(shadow_cm[cvr_pkg::POS_CM_EN]))
    else $error("in-phase buffer enable not copied from shadow");

  a_quad_cm: assert property (@(posedge clk_sys) disable iff (!rst_b)
    update_rise && adc_select[cvr_pkg::POS_QUAD_SEL]
      |=> adc_q_cfg.cm_en == $past(shadow_cm[cvr_pkg::POS_CM_EN]))
    else $error("quadrature buffer enable not copied from shadow");
endmodule

`default_nettype wire

// ===== cvr_host_model.sv
// Host model that issues byte writes and reads to the config bank
`timescale 1ns/100ps
`default_nettype none
module cvr_host_model (
  input wire logic clk_sys,
  output var cvr_pkg::cvr_req_s req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  initial req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
  // One strobe per byte; released lines show inverted values, not stale ones
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_sys);
    #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    xfer(1'b0, a, 8'h00);
    d = rd_data;
    v = rd_valid;
  endtask
  // Select first, then a rising update bit, then re-arm it
  task automatic apply(input logic [1:0] sel);
    write_reg(cvr_pkg::OFS_ADC_SELECT, {6'h00, sel});
    write_reg(cvr_pkg::OFS_TRANSFER, 8'h01);
    write_reg(cvr_pkg::OFS_TRANSFER, 8'h00);
  endtask
endmodule
`default_nettype wire

// ===== converter_config_registers_tb.sv
// Self-checking testbench of the converter config bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module converter_config_registers_tb;
  logic clk_sys, rst_b, clk_en, dll_locked, rd_valid, vld, sdio_input_only, lsb_first;
  logic rx_common_mode_buffer_en, decimator_bypass, second_interp_bypass, first_interp_bypass;
  logic [7:0] rd_data, rdv;
  cvr_pkg::cvr_aux_s aux_status;
  cvr_pkg::cvr_req_s req;
  cvr_pkg::cvr_adc_cfg_s adc_i_cfg, adc_q_cfg, exp_i, exp_q;
  int fails = 0;
  int samples_checked = 0;
  cvr_config_regs cvr_config_regs_inst (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .req(req), .dll_locked(dll_locked), .aux_status(aux_status), .rd_data(rd_data),
    .rd_valid(rd_valid), .sdio_input_only(sdio_input_only), .lsb_first(lsb_first),
    .adc_i_cfg(adc_i_cfg), .adc_q_cfg(adc_q_cfg),
    .rx_common_mode_buffer_en(rx_common_mode_buffer_en),
    .decimator_bypass(decimator_bypass), .second_interp_bypass(second_interp_bypass),
    .first_interp_bypass(first_interp_bypass));
  cvr_host_model cvr_host_model_inst (.clk_sys(clk_sys), .req(req), .rd_data(rd_data),
    .rd_valid(rd_valid));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cvr_host_model_inst.write_reg(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    cvr_host_model_inst.read_reg(a, rdv, vld);
    `CHK("rd_valid", 1'b1, vld)
    `CHK("rd_data", e, rdv)
  endtask
  task automatic t_defaults;
    rd_chk(cvr_pkg::OFS_PORT_SETUP, 8'h00);
    rd_chk(cvr_pkg::OFS_LOOP_DIV_M, 8'h01);
    rd_chk(cvr_pkg::OFS_TRANSFER, 8'h00);
    wr(8'h01, 8'h5A);
    rd_chk(8'h01, 8'h00);
    `CHK("cfg", 14'h0000, {adc_i_cfg, adc_q_cfg})
    $display("test defaults done");
  endtask
  task automatic t_port;
    logic [7:0] v [5] = '{8'h80, 8'h01, 8'h40, 8'h02, 8'h00};
    for (int k = 0; k < 5; k++) begin
      wr(cvr_pkg::OFS_PORT_SETUP, v[k]);
      `CHK("sdio_input_only", v[k][7] | v[k][0], sdio_input_only)
      `CHK("lsb_first", v[k][6] | v[k][1], lsb_first)
    end
    $display("test port setup done");
  endtask
  task automatic t_filter;
    for (int k = 3; k < 6; k++) begin
      wr(cvr_pkg::OFS_FILTER, 8'h01 << k);
      `CHK("bypass", 3'b001 << (k - 3), {decimator_bypass, second_interp_bypass, first_interp_bypass})
    end
    wr(cvr_pkg::OFS_FILTER, 8'hFF);
    rd_chk(cvr_pkg::OFS_FILTER, 8'h3F);
    $display("test filter done");
  endtask
  task automatic t_update;
    logic [5:0] ofs [4] = '{6'h1F, 6'h20, 6'h3F, 6'h01};
    exp_i = '0;
    exp_q = '0;
    for (int s = 0; s < 4; s++) begin
      wr(cvr_pkg::OFS_CM_BUF, {6'h00, s[0], 1'b0});
      wr(cvr_pkg::OFS_ADC_OFFSET, {2'b00, ofs[s]});
      `CHK("held cfg", {exp_i, exp_q}, {adc_i_cfg, adc_q_cfg})
      rd_chk(cvr_pkg::OFS_ADC_OFFSET, {2'b00, ofs[s]});
      cvr_host_model_inst.apply(s[1:0]);
      rd_chk(cvr_pkg::OFS_ADC_SELECT, {6'h00, s[1:0]});
      if (s[0]) exp_i = {s[0], ofs[s]};
      if (s[1]) exp_q = {s[0], ofs[s]};
      `CHK("adc cfg", {exp_i, exp_q}, {adc_i_cfg, adc_q_cfg})
      `CHK("cm buffer", exp_i.cm_en | exp_q.cm_en, rx_common_mode_buffer_en)
    end
    $display("test update done");
  endtask
  task automatic t_soft_reset;
    wr(cvr_pkg::OFS_FILTER, 8'h38);
    wr(cvr_pkg::OFS_PORT_SETUP, 8'h84);
    `CHK("filters", 3'b000, {decimator_bypass, second_interp_bypass, first_interp_bypass})
    `CHK("cfg", 14'h0000, {adc_i_cfg, adc_q_cfg})
    `CHK("sdio_input_only", 1'b1, sdio_input_only)
    rd_chk(cvr_pkg::OFS_PORT_SETUP, 8'h84);
    rd_chk(cvr_pkg::OFS_ADC_OFFSET, 8'h00);
    wr(cvr_pkg::OFS_FILTER, 8'h08);
    wr(cvr_pkg::OFS_PORT_SETUP, 8'h04);
    `CHK("first_interp_bypass", 1'b1, first_interp_bypass)
    wr(cvr_pkg::OFS_PORT_SETUP, 8'h00);
    wr(cvr_pkg::OFS_FILTER, 8'h08);
    wr(cvr_pkg::OFS_PORT_SETUP, 8'h20);
    `CHK("first_interp_bypass", 1'b0, first_interp_bypass)
    wr(cvr_pkg::OFS_PORT_SETUP, 8'h00);
    $display("test soft reset done");
  endtask
  task automatic t_misc;
    dll_locked = 1'b1;
    aux_status = '{result: 12'hA5C, done: 1'b1, chan: 3'h6};
    wr(cvr_pkg::OFS_LOOP_DIV_M, 8'h85);
    rd_chk(cvr_pkg::OFS_LOOP_DIV_M, 8'h85);
    wr(cvr_pkg::OFS_AUX_HIGH, 8'h00);
    rd_chk(cvr_pkg::OFS_AUX_HIGH, 8'hA5);
    rd_chk(cvr_pkg::OFS_AUX_LOW, 8'hCE);
    clk_en = 1'b0;
    wr(cvr_pkg::OFS_FILTER, 8'h20);
    clk_en = 1'b1;
    `CHK("decimator_bypass", 1'b0, decimator_bypass)
    $display("test status and enable done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    dll_locked = 1'b0;
    aux_status = '0;
    repeat (5) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    t_defaults;
    t_port;
    t_filter;
    t_update;
    t_soft_reset;
    t_misc;
    finish_test;
  end
  // Whole run needs well under 200 transfers of two cycles each
  initial begin
    #40000;
    fails++;
    finish_test;
  end
endmodule
`default_nettype wire
